// >>> stack_exec.sv
`timescale 1ns/1ps
module stack_exec
	import stack_exec_pkg::*;
#(
	parameter int unsigned ADDR_W  = 10,  // Stack memory address width
	parameter int unsigned ENTRY_W = 5    // Entry table index width
) (
	input  wire logic                     clk,          // 100 MHz clock
	input  wire logic                     rst,          // Synchronous reset, high
	input  wire logic                     inst_valid,   // Instruction offered
	input  wire stack_exec_pkg::instr_s   inst,         // Instruction fields
	output logic                          inst_ready,   // Instruction accepted
	output logic [stack_exec_pkg::WORD_W-1:0] pc_q,     // Segment-relative counter
	output stack_exec_pkg::cc_e           cc_q,         // Condition code
	output logic [ADDR_W-1:0]             sp_q,         // Stack top pointer
	output logic [ADDR_W-1:0]             fp_q,         // Frame pointer
	input  wire logic                     entry_we,     // Entry table write
	input  wire logic [ENTRY_W-1:0]       entry_idx,    // Entry table index
	input  wire logic [stack_exec_pkg::WORD_W-1:0] entry_pc, // Entry point
	input  wire logic [ADDR_W-1:0]        data_base_in, // Data base, taken at reset
	input  wire logic                     load_we,      // Memory preload write
	input  wire logic [ADDR_W-1:0]        load_addr,    // Preload / peek address
	input  wire logic [stack_exec_pkg::WORD_W-1:0] load_data, // Preload data
	output logic [stack_exec_pkg::WORD_W-1:0] peek_q    // Word at load_addr, registered
);
	import stack_exec_pkg::*;

	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	if (ADDR_W < 4 || ADDR_W > WORD_W || ENTRY_W < 1 || ENTRY_W > 12) begin : g_bad
		$error("stack_exec: ADDR_W or ENTRY_W out of range");
	end

	localparam int unsigned DEPTH   = 1 << ADDR_W;
	localparam int unsigned ENTRIES = 1 << ENTRY_W;

	typedef enum {
		st_run,
		st_mark
	} state_e;

	// Frame-relative address, wrapping inside the stack memory
	function automatic logic [ADDR_W-1:0] frame_addr(input logic [ADDR_W-1:0] fp,
	                                                 input logic [WORD_W-1:0] off);
		frame_addr = fp - off[ADDR_W-1:0];
	endfunction : frame_addr

	// Signed comparison used to build the condition code
	function automatic cc_e compare(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
		if ($signed(a) < $signed(b)) begin
			compare = cc_less;
		end else if (a == b) begin
			compare = cc_equal;
		end else begin
			compare = cc_greater;
		end
	endfunction : compare

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [WORD_W-1:0] mem [DEPTH];
	logic [WORD_W-1:0] entry_tab [ENTRIES];
	state_e            state_q;
	logic [1:0]        mk_cnt_q;      // Marker word being written
	logic [ADDR_W-1:0] mk_base_q;     // Stack top when the call began
	logic [WORD_W-1:0] ret_q;         // Return word for the marker
	logic [WORD_W-1:0] target_q;      // Entry point from the table
	logic [ADDR_W-1:0] data_base_q;   // Data base register

	// ---------------------------------------------------------------
	// Operand decode and memory reads
	// ---------------------------------------------------------------
	wire               fire      = inst_valid && inst_ready;
	wire [ADDR_W-1:0]  fr_addr   = frame_addr(fp_q, inst.operand);
	wire [WORD_W-1:0]  tos       = mem[sp_q];
	wire [WORD_W-1:0]  fr_word   = mem[fr_addr];
	wire [WORD_W-1:0]  link_word = mem[fp_q];
	wire [WORD_W-1:0]  ret_word  = mem[fp_q - ADDR_W'(MK_RET_BACK)];
	wire [WORD_W-1:0]  product   = WORD_W'(fr_word * tos);
	wire [WORD_W-1:0]  diff      = tos - inst.operand;
	wire [ADDR_W-1:0]  st_addr   = inst.data_rel ? data_base_q + inst.operand[ADDR_W-1:0]
	                                             : fr_addr;
	wire [ADDR_W-1:0]  exit_fp   = fp_q - link_word[ADDR_W-1:0];
	wire [ADDR_W-1:0]  exit_sp   = fp_q - ADDR_W'(MARKER_WORDS) - inst.operand[ADDR_W-1:0];
	wire [ADDR_W-1:0]  mk_addr   = mk_base_q + ADDR_W'(mk_cnt_q) + ADDR_W'(1);
	wire [ADDR_W-1:0]  new_fp    = mk_base_q + ADDR_W'(MARKER_WORDS);
	wire [ADDR_W-1:0]  sp_inc    = sp_q + ADDR_W'(1);
	wire [ADDR_W-1:0]  sp_dec    = sp_q - ADDR_W'(1);
	wire               is_op_run = fire && state_q == st_run;

	assign inst_ready = (state_q == st_run) && !rst;

	// ---------------------------------------------------------------
	// Memory write select: marker words, executed ops, then preload
	// ---------------------------------------------------------------
	logic              mem_we;
	logic [ADDR_W-1:0] mem_wa;
	logic [WORD_W-1:0] mem_wd;

	always_comb begin
		mem_we = 1'b0;
		mem_wa = sp_inc;
		mem_wd = ZERO_WORD;
		if (state_q == st_mark) begin
			mem_we = 1'b1;
			mem_wa = mk_addr;
			case (mk_cnt_q)
				2'h1:    mem_wd = ret_q;
				2'h2:    mem_wd = {{(WORD_W-2){1'b0}}, cc_q};
				2'h3:    mem_wd = WORD_W'(new_fp - fp_q);
				default: mem_wd = INDEX_SAVE;
			endcase
		end else if (is_op_run) begin
			case (inst.op)
				push_zero_pair_op: begin
					mem_we = 1'b1;
					mem_wd = ZERO_WORD;
				end
				push_immediate_op: begin
					mem_we = 1'b1;
					mem_wd = inst.operand;
				end
				load_from_frame_op: begin
					mem_we = 1'b1;
					mem_wd = fr_word;
				end
				subtract_immediate_op: begin
					mem_we = 1'b1;
					mem_wa = sp_q;
					mem_wd = diff;
				end
				multiply_from_memory_op: begin
					mem_we = 1'b1;
					mem_wa = sp_q;
					mem_wd = product;
				end
				store_to_memory_op: begin
					mem_we = 1'b1;
					mem_wa = st_addr;
					mem_wd = tos;
				end
				default: mem_we = 1'b0;
			endcase
		end else if (load_we) begin
			mem_we = 1'b1;
			mem_wa = load_addr;
			mem_wd = load_data;
		end
	end

	// Memory and entry table; no reset, contents are preloaded from outside
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
		if (entry_we) begin
			entry_tab[entry_idx] <= entry_pc;
		end
		peek_q <= mem[load_addr];
	end

	// ---------------------------------------------------------------
	// Pointers, counter and condition code
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q     <= st_run;
			mk_cnt_q    <= 2'h0;
			mk_base_q   <= '0;
			ret_q       <= ZERO_WORD;
			target_q    <= ZERO_WORD;
			pc_q        <= ZERO_WORD;
			cc_q        <= cc_equal;
			sp_q        <= '0;
			fp_q        <= '0;
			data_base_q <= data_base_in;
		end else if (state_q == st_mark) begin
			// One marker word per cycle keeps the memory single-ported
			mk_cnt_q <= mk_cnt_q + 2'h1;
			if (mk_cnt_q == MK_LAST_IDX) begin
				state_q <= st_run;
				sp_q    <= new_fp;
				fp_q    <= new_fp;
				pc_q    <= target_q;
			end
		end else if (fire) begin
			pc_q <= pc_q + ONE_WORD;
			case (inst.op)
				push_zero_pair_op, push_immediate_op, load_from_frame_op: begin
					sp_q <= sp_inc;
				end
				compare_immediate_op: begin
					cc_q <= compare(tos, inst.operand);
					sp_q <= sp_dec;
				end
				store_to_memory_op: sp_q <= sp_dec;
				branch_if_unequal_op: begin
					if (cc_q != cc_equal) begin
						pc_q <= pc_q + inst.operand;
					end
				end
				branch_always_op: pc_q <= pc_q + inst.operand;
				procedure_call_op: begin
					state_q   <= st_mark;
					mk_cnt_q  <= 2'h0;
					mk_base_q <= sp_q;
					ret_q     <= pc_q + ONE_WORD;
					target_q  <= entry_tab[inst.operand[ENTRY_W-1:0]];
				end
				procedure_exit_op: begin
					fp_q <= exit_fp;
					sp_q <= exit_sp;
					pc_q <= ret_word;
				end
				default: sp_q <= sp_q;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	wire run_fire = fire && state_q == st_run;

	compare_pop_a: assert property (run_fire && inst.op == compare_immediate_op |=>
		sp_q == $past(sp_q) - ADDR_W'(1) && cc_q == compare($past(tos), $past(inst.operand)))
		else $error("compare did not pop or set condition");
	branch_taken_a: assert property (run_fire && inst.op == branch_if_unequal_op
		&& cc_q != cc_equal |=> pc_q == $past(pc_q) + $past(inst.operand))
		else $error("taken branch target wrong");
	branch_fall_a: assert property (run_fire && inst.op == branch_if_unequal_op
		&& cc_q == cc_equal |=> pc_q == $past(pc_q) + ONE_WORD)
		else $error("untaken branch did not fall through");
	push_zero_a: assert property (run_fire && inst.op == push_zero_pair_op |=>
		sp_q == $past(sp_q) + ADDR_W'(1) && tos == ZERO_WORD)
		else $error("push zero wrong");
	frame_load_a: assert property (run_fire && inst.op == load_from_frame_op |=>
		tos == $past(fr_word) && sp_q == $past(sp_q) + ADDR_W'(1))
		else $error("frame load wrong");
	sub_imm_a: assert property (run_fire && inst.op == subtract_immediate_op |=>
		tos == $past(diff) && sp_q == $past(sp_q))
		else $error("subtract immediate wrong");
	push_imm_a: assert property (run_fire && inst.op == push_immediate_op |=>
		tos == $past(inst.operand) && sp_q == $past(sp_q) + ADDR_W'(1))
		else $error("push immediate wrong");

	// Call checks look five edges on: the taking edge plus four marker writes
	call_len_a: assert property (run_fire && inst.op == procedure_call_op |=>
		!inst_ready [*4] ##1 inst_ready && sp_q == $past(sp_q, 5) + ADDR_W'(MARKER_WORDS))
		else $error("call marker not four words");
	call_stat_a: assert property (run_fire && inst.op == procedure_call_op |=>
		##4 mem[sp_q - ADDR_W'(MK_STAT_BACK)] == {{(WORD_W-2){1'b0}}, $past(cc_q, 5)})
		else $error("marker status word wrong");
	call_ret_a: assert property (run_fire && inst.op == procedure_call_op |=>
		##4 mem[sp_q - ADDR_W'(MK_RET_BACK)] == $past(pc_q, 5) + ONE_WORD)
		else $error("marker return word wrong");
	call_link_a: assert property (run_fire && inst.op == procedure_call_op |=>
		##4 link_word == WORD_W'(fp_q - $past(fp_q, 5)))
		else $error("marker link wrong");
	call_ptr_a: assert property (run_fire && inst.op == procedure_call_op |=>
		##4 sp_q == fp_q)
		else $error("pointers differ after call");
	// Holds only while the entry table is left alone during the marker
	call_target_a: assert property (run_fire && inst.op == procedure_call_op |=>
		##4 pc_q == entry_tab[$past(inst.operand[ENTRY_W-1:0], 5)])
		else $error("call target wrong");
	exit_frame_a: assert property (run_fire && inst.op == procedure_exit_op |=>
		fp_q == $past(exit_fp) && sp_q == $past(exit_sp) && pc_q == $past(ret_word))
		else $error("exit restore wrong");
	mult_mem_a: assert property (run_fire && inst.op == multiply_from_memory_op |=>
		tos == $past(product))
		else $error("multiply from memory wrong");
	store_pop_a: assert property (run_fire && inst.op == store_to_memory_op |=>
		sp_q == $past(sp_q) - ADDR_W'(1) && mem[$past(st_addr)] == $past(tos))
		else $error("store wrong");

	call_cov_c:   cover property (run_fire && inst.op == procedure_call_op ##5 inst_ready);
	exit_cov_c:   cover property (run_fire && inst.op == procedure_exit_op);
	branch_cov_c: cover property (run_fire && inst.op == branch_if_unequal_op
		&& cc_q != cc_equal);
	store_db_c:   cover property (run_fire && inst.op == store_to_memory_op && inst.data_rel);

endmodule : stack_exec

// >>> stack_exec_pkg.sv
package stack_exec_pkg;

	// ---------------------------------------------------------------
	// Widths and marker layout
	// ---------------------------------------------------------------
	localparam int unsigned WORD_W       = 16;
	localparam int unsigned MARKER_WORDS = 4;          // Words in a call marker
	localparam logic [1:0]  MK_LAST_IDX  = 2'h3;       // Last marker word to write
	localparam logic [2:0]  MK_RET_BACK  = 3'h2;       // Return word, below frame top
	localparam logic [2:0]  MK_STAT_BACK = 3'h1;       // Status word, below frame top
	localparam logic [WORD_W-1:0] ZERO_WORD  = 16'h0000;
	localparam logic [WORD_W-1:0] INDEX_SAVE = 16'h0000; // Lowest marker word
	localparam logic [WORD_W-1:0] ONE_WORD   = 16'h0001; // Program counter step

	// ---------------------------------------------------------------
	// Operations, condition code and instruction carrier
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		push_zero_pair_op,
		push_immediate_op,
		load_from_frame_op,
		subtract_immediate_op,
		compare_immediate_op,
		branch_if_unequal_op,
		branch_always_op,
		multiply_from_memory_op,
		store_to_memory_op,
		procedure_call_op,
		procedure_exit_op
	} op_e;

	typedef enum logic [1:0] {
		cc_less,
		cc_equal,
		cc_greater
	} cc_e;

	typedef struct packed {
		op_e              op;        // Operation
		logic             data_rel;  // Store: 1 = data base, 0 = frame relative
		logic [WORD_W-1:0] operand;  // Immediate, offset, displacement or count
	} instr_s;

endpackage : stack_exec_pkg

// >>> tb_stack_exec.sv
`timescale 1ns/1ps
module tb_stack_exec;
	import stack_exec_pkg::*;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam int AW = 10;
	localparam int EW = 5;
	logic              clk, rst, inst_valid, inst_ready, entry_we, load_we;
	instr_s            inst;
	logic [WORD_W-1:0] pc_q, entry_pc, load_data, peek_q;
	cc_e               cc_q;
	logic [AW-1:0]     sp_q, fp_q, data_base_in, load_addr;
	logic [EW-1:0]     entry_idx;
	int                bad_count, n_tests;

	stack_exec #(.ADDR_W(AW), .ENTRY_W(EW)) stack_exec_inst (
		.clk(clk), .rst(rst), .inst_valid(inst_valid), .inst(inst), .inst_ready(inst_ready),
		.pc_q(pc_q), .cc_q(cc_q), .sp_q(sp_q), .fp_q(fp_q), .entry_we(entry_we),
		.entry_idx(entry_idx), .entry_pc(entry_pc), .data_base_in(data_base_in),
		.load_we(load_we), .load_addr(load_addr), .load_data(load_data), .peek_q(peek_q));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask : check

	// Offer one instruction and hold it until it is taken; ready is sampled
	// at the falling edge because it only moves at rising edges
	task automatic issue(input op_e code, input logic rel, input logic [15:0] opd);
		logic r;
		r = 1'b0;
		@(posedge clk);
		inst_valid <= 1'b1;
		inst <= '{op: code, data_rel: rel, operand: opd};
		for (int n = 0; n < 50 && !r; n++) begin
			@(negedge clk);
			r = (inst_ready === 1'b1);
			@(posedge clk);
		end
		inst_valid <= 1'b0;
		@(negedge clk);
		check({15'h0000, r}, 16'h0001, "instruction taken");
	endtask : issue

	task automatic peek(input logic [AW-1:0] a, output logic [15:0] v);
		@(posedge clk);
		load_addr <= a;
		@(posedge clk);
		@(negedge clk);
		v = peek_q;
	endtask : peek

	// Preload only while no instruction runs, else the write is dropped
	task automatic poke(input logic [AW-1:0] a, input logic [15:0] d);
		@(posedge clk);
		load_we <= 1'b1;
		load_addr <= a;
		load_data <= d;
		@(posedge clk);
		load_we <= 1'b0;
	endtask : poke

	function automatic logic [15:0] w(input logic [AW-1:0] p);
		return {6'h00, p};
	endfunction : w

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_push;
		logic [15:0] v;
		poke(10'h001, 16'hFFFF);
		issue(push_zero_pair_op, 1'b0, 16'h0000);
		check(w(sp_q), 16'h0001, "push zero sp");
		peek(10'h001, v);
		check(v, 16'h0000, "push zero word");
		issue(push_immediate_op, 1'b0, 16'h0005);
		peek(10'h002, v);
		check(v, 16'h0005, "push immediate");
		issue(subtract_immediate_op, 1'b0, 16'h0001);
		peek(10'h002, v);
		check(v, 16'h0004, "decrement top");
		check(w(sp_q), 16'h0002, "subtract keeps sp");
	endtask : t_push

	// Call at pc 3 through entry 3; old sp 2, old fp 0
	task automatic t_call;
		logic [15:0] v;
		int          n;
		@(posedge clk);
		entry_we <= 1'b1;
		entry_idx <= 5'h03;
		entry_pc <= 16'h0040;
		@(posedge clk);
		entry_we <= 1'b0;
		issue(procedure_call_op, 1'b0, 16'h0003);
		n = 0;
		while (inst_ready !== 1'b1 && n < 20) begin
			n++;
			@(negedge clk);
		end
		check(16'(n), 16'h0004, "marker stall cycles");
		check(w(sp_q), 16'h0006, "sp after call");
		check(w(fp_q), 16'h0006, "fp equals sp");
		check(pc_q, 16'h0040, "entry target");
		peek(10'h004, v);
		check(v, 16'h0004, "saved return");
		peek(10'h006, v);
		check(v, 16'h0006, "frame link");
	endtask : t_call

	task automatic t_body;
		logic [15:0] v;
		issue(load_from_frame_op, 1'b0, 16'h0004);
		peek(10'h007, v);
		check(v, 16'h0004, "frame copy");
		peek(10'h002, v);
		check(v, 16'h0004, "frame source kept");
		issue(compare_immediate_op, 1'b0, 16'h0000);
		check({14'h0000, cc_q}, {14'h0000, cc_greater}, "compare greater");
		check(w(sp_q), 16'h0006, "compare pops");
		issue(branch_if_unequal_op, 1'b0, 16'h0004);
		check(pc_q, 16'h0046, "branch taken");
		issue(push_immediate_op, 1'b0, 16'h0003);
		issue(multiply_from_memory_op, 1'b0, 16'h0004);
		peek(10'h007, v);
		check(v, 16'h000C, "product");
		issue(store_to_memory_op, 1'b0, 16'h0005);
		check(w(sp_q), 16'h0006, "store pops");
		peek(10'h001, v);
		check(v, 16'h000C, "frame store");
	endtask : t_body

	task automatic t_exit;
		issue(procedure_exit_op, 1'b0, 16'h0001);
		check(w(fp_q), 16'h0000, "fp restored");
		check(w(sp_q), 16'h0001, "sp past marker");
		check(pc_q, 16'h0004, "return pc");
	endtask : t_exit

	task automatic t_misc;
		logic [15:0] v;
		issue(push_immediate_op, 1'b0, 16'h0055);
		issue(store_to_memory_op, 1'b1, 16'h0002);
		check(w(sp_q), 16'h0001, "data store pops");
		peek(10'h102, v);
		check(v, 16'h0055, "data base store");
		issue(push_immediate_op, 1'b0, 16'h8000);
		issue(compare_immediate_op, 1'b0, 16'h0000);
		check({14'h0000, cc_q}, {14'h0000, cc_less}, "signed less");
		issue(branch_if_unequal_op, 1'b0, 16'hFFFE);
		check(pc_q, 16'h0006, "backward branch");
		issue(push_immediate_op, 1'b0, 16'h0007);
		issue(compare_immediate_op, 1'b0, 16'h0007);
		check({14'h0000, cc_q}, {14'h0000, cc_equal}, "equal");
		issue(branch_if_unequal_op, 1'b0, 16'h0004);
		check(pc_q, 16'h0009, "branch not taken");
		issue(branch_always_op, 1'b0, 16'h0003);
		check(pc_q, 16'h000C, "unconditional branch");
	endtask : t_misc

	// ---------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ---------------------------------------------------------------
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	// Data base is tied: it is only captured during reset
	initial begin
		rst = 1'b1;
		inst_valid = 1'b0;
		inst = '{op: push_zero_pair_op, data_rel: 1'b0, operand: 16'h0000};
		entry_we = 1'b0;
		entry_idx = 5'h00;
		entry_pc = 16'h0000;
		data_base_in = 10'h100;
		load_we = 1'b0;
		load_addr = 10'h000;
		load_data = 16'h0000;
		bad_count = 0;
		n_tests = 0;
		@(posedge clk);
		@(negedge clk);
		check({15'h0000, inst_ready}, 16'h0000, "ready low in reset");
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check(pc_q, 16'h0000, "reset pc");
		check(w(sp_q), 16'h0000, "reset sp");
		check(w(fp_q), 16'h0000, "reset fp");
		check({14'h0000, cc_q}, {14'h0000, cc_equal}, "reset condition");
		check({15'h0000, inst_ready}, 16'h0001, "ready after reset");
		t_push();
		t_call();
		t_body();
		t_exit();
		t_misc();
		report_and_stop();
	end

	// The sequence needs well under 300 cycles
	initial begin
		#20000;
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		report_and_stop();
	end

endmodule : tb_stack_exec
